// *** logic/fwia_pkg.sv ***
// fwia_pkg: constants for the fifo/waveform interrupt autovector block
package fwia_pkg;
    // ****************************************
    // source layout and vector codes
    // ****************************************
    localparam int NUM_SOURCES = 14;
    localparam logic [7:0] VEC_BASE = 8'h80;
    localparam logic [7:0] VEC_STEP = 8'h04;
    localparam logic [7:0] VEC_LEVEL_A = 8'h80;
    localparam logic [7:0] VEC_EMPTY_A = 8'h90;
    localparam logic [7:0] VEC_FULL_A = 8'hA0;
    localparam logic [7:0] VEC_WAVE_DONE = 8'hB0;
    localparam logic [7:0] VEC_WAVE_EVENT = 8'hB4;
    localparam logic [7:0] VEC_NONE = 8'h00;
    // source bit positions, bit 0 is highest priority
    localparam int SRC_LEVEL_POS = 0;
    localparam int SRC_EMPTY_POS = 4;
    localparam int SRC_FULL_POS = 8;
    localparam int SRC_DONE_POS = 12;
    localparam int SRC_WAVE_POS = 13;
    // ****************************************
    // code addresses of the vector sequence
    // ****************************************
    localparam logic [15:0] ADDR_ENTRY = 16'h0053;
    localparam logic [15:0] ADDR_PAGE = 16'h0054;
    localparam logic [15:0] ADDR_LOW = 16'h0055;
    // reset value of the substitute enable
    localparam logic SUBST_EN_RST = 1'b0;
    typedef enum logic [1:0] {
        FWIA_IDLE,
        FWIA_VECTORING
    } fwia_state_type;
endpackage

// *** logic/fwia_prio_enc.sv ***
// fwia_prio_enc: fixed priority encoder giving the vector code
`timescale 1ns/1ns
module fwia_prio_enc #(
    parameter int N = 14
) (
    input wire logic [N-1:0] pending,
    output logic any,
    output logic [7:0] code
);
    import fwia_pkg::*;

    // lowest index wins, codes step by four from the base
    always_comb begin
        any = 1'b0;
        code = VEC_NONE;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                any = 1'b1;
                code = VEC_BASE + 8'(i) * VEC_STEP;
            end
        end
    end
endmodule // fwia_prio_enc

// *** logic/fwia_autovector.sv ***
// fwia_autovector: fifo/waveform interrupt sharing and autovectoring
//
// Operation
// - fourteen sources share one interrupt request
// - level flags priorities 1-4, codes 80-8C
// - empty flags priorities 5-8, codes 90-9C
// - full flags priorities 9-12, codes A0-AC
// - wave done 13 B0, wave event 14 B4
// - smallest pending priority number wins
// - substitute code only while enable is set
// - firmware page at 0054, code at 0055
// - fourteen distinct targets within one page
// - core pushes pc, jumps to 0053
`timescale 1ns/1ns
module fwia_autovector #(
    parameter int N = 14
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [3:0] LEVEL_FLAGS,
    input wire logic [3:0] EMPTY_FLAGS,
    input wire logic [3:0] FULL_FLAGS,
    input wire logic WAVE_DONE,
    input wire logic WAVE_EVENT,
    input wire logic [N-1:0] SRC_CLEAR,
    input wire logic SUBST_EN_WR,
    input wire logic SUBST_EN_VAL,
    input wire logic IRQ_ACK,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic [7:0] FETCH_MEM_DATA,
    output logic [7:0] FETCH_DATA,
    output logic FIFO_EVENT_IRQ_LINE,
    output logic [7:0] FIFO_EVENT_VECTOR_CODE,
    output logic [N-1:0] PENDING,
    output logic SUBST_EN
);
    import fwia_pkg::*;

    logic [N-1:0] events;
    logic [N-1:0] pending_r;
    logic [N-1:0] pending_nxt;
    logic fifo_vector_substitute_en_r;
    logic [7:0] code;
    logic any;
    fwia_state_type state_r;

    // ****************************************
    // source collection
    // ****************************************
    // order of the vector fixes priority
    assign events = {WAVE_EVENT, WAVE_DONE, FULL_FLAGS, EMPTY_FLAGS,
                     LEVEL_FLAGS};

    // sticky pending, a new event beats a same-cycle clear
    assign pending_nxt = (pending_r & ~SRC_CLEAR) | events;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pending_r <= '0;
        end else if (CLK_EN) begin
            pending_r <= pending_nxt;
        end
    end

    // ****************************************
    // priority and vector code
    // ****************************************
    // lowest priority number gives the code
    fwia_prio_enc #(.N(N)) u_enc (
        .pending(pending_r),
        .any(any),
        .code(code)
    );

    // substitute enable setting
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            fifo_vector_substitute_en_r <= SUBST_EN_RST;
        end else if (CLK_EN && SUBST_EN_WR) begin
            fifo_vector_substitute_en_r <= SUBST_EN_VAL;
        end
    end

    // registered code and shared request line
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            FIFO_EVENT_VECTOR_CODE <= VEC_NONE;
            FIFO_EVENT_IRQ_LINE <= 1'b0;
        end else if (CLK_EN) begin
            FIFO_EVENT_VECTOR_CODE <= code;
            FIFO_EVENT_IRQ_LINE <= any;
        end
    end

    // ****************************************
    // vector fetch sequence
    // ****************************************
    // tracks the core from taking the interrupt until it fetches 0055
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_r <= FWIA_IDLE;
        end else if (CLK_EN) begin
            case (state_r)
                FWIA_IDLE: begin
                    if (IRQ_ACK) begin
                        state_r <= FWIA_VECTORING;
                    end
                end
                FWIA_VECTORING: begin
                    if (FETCH_ADDR == ADDR_LOW) begin
                        state_r <= FWIA_IDLE;
                    end
                end
                default: begin
                    state_r <= FWIA_IDLE;
                end
            endcase
        end
    end

    // low jump byte replaced, page byte from memory
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            FETCH_DATA <= 8'h00;
        end else if (CLK_EN) begin
            if (fifo_vector_substitute_en_r && FETCH_ADDR == ADDR_LOW) begin
                FETCH_DATA <= FIFO_EVENT_VECTOR_CODE;
            end else begin
                FETCH_DATA <= FETCH_MEM_DATA;
            end
        end
    end

    assign PENDING = pending_r;
    assign SUBST_EN = fifo_vector_substitute_en_r;

    // ****************************************
    // checks
    // ****************************************
    property p_subst;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && fifo_vector_substitute_en_r && FETCH_ADDR == ADDR_LOW
        |=> FETCH_DATA == $past(FIFO_EVENT_VECTOR_CODE);
    endproperty
    a_subst: assert property (p_subst)
        else $error("vector not substituted");

    property p_pass;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && !fifo_vector_substitute_en_r
        |=> FETCH_DATA == $past(FETCH_MEM_DATA);
    endproperty
    a_pass: assert property (p_pass)
        else $error("fetch altered while disabled");

    property p_page;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && FETCH_ADDR == ADDR_PAGE
        |=> FETCH_DATA == $past(FETCH_MEM_DATA);
    endproperty
    a_page: assert property (p_page)
        else $error("page byte altered");

    property p_top;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && pending_r[0] |=> FIFO_EVENT_VECTOR_CODE == VEC_LEVEL_A;
    endproperty
    a_top: assert property (p_top)
        else $error("top priority code wrong");

    property p_empty;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && pending_r[SRC_EMPTY_POS] && pending_r[3:0] == 4'h0
        |=> FIFO_EVENT_VECTOR_CODE == VEC_EMPTY_A;
    endproperty
    a_empty: assert property (p_empty)
        else $error("empty code wrong");

    property p_full;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && pending_r[SRC_FULL_POS] && pending_r[7:0] == 8'h00
        |=> FIFO_EVENT_VECTOR_CODE == VEC_FULL_A;
    endproperty
    a_full: assert property (p_full)
        else $error("full code wrong");

    property p_done;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && pending_r[SRC_DONE_POS] && pending_r[11:0] == 12'h000
        |=> FIFO_EVENT_VECTOR_CODE == VEC_WAVE_DONE;
    endproperty
    a_done: assert property (p_done)
        else $error("wave done code wrong");

    property p_entry;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && FETCH_ADDR == ADDR_ENTRY
        |=> FETCH_DATA == $past(FETCH_MEM_DATA);
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry jump byte altered");

    property p_track;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && IRQ_ACK && state_r == FWIA_IDLE
        |=> state_r == FWIA_VECTORING;
    endproperty
    a_track: assert property (p_track)
        else $error("interrupt entry not tracked");

    property p_wave;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && pending_r == 14'h2000
        |=> FIFO_EVENT_VECTOR_CODE == VEC_WAVE_EVENT;
    endproperty
    a_wave: assert property (p_wave)
        else $error("wave event code wrong");

    property p_irq;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN |=> FIFO_EVENT_IRQ_LINE == ($past(pending_r) != '0);
    endproperty
    a_irq: assert property (p_irq)
        else $error("request line mismatch");

    property p_sticky;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        CLK_EN && events[SRC_DONE_POS] |=> pending_r[SRC_DONE_POS];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("event lost");

    property p_range;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        any |-> code >= VEC_BASE && code <= VEC_WAVE_EVENT
            && code[1:0] == 2'b00;
    endproperty
    a_range: assert property (p_range)
        else $error("code outside page table");
endmodule // fwia_autovector

// *** verification/fwia_core_model.sv ***
// fwia_core_model: core side fetching the vector jump sequence
`timescale 1ns/1ns
module fwia_core_model #(
    parameter logic [7:0] PAGE = 8'h12,
    parameter logic [7:0] OPCODE = 8'h02
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [7:0] fetch_data,
    output logic [15:0] fetch_addr,
    output logic [7:0] mem_data,
    output logic ack,
    output logic done,
    output logic [7:0] op_got,
    output logic [7:0] page_got,
    output logic [7:0] vec_got
);
    import fwia_pkg::*;
    logic [2:0] st_r;
    // code memory: jump opcode, preloaded page, filler low byte
    always_comb begin
        case (fetch_addr)
            ADDR_ENTRY: mem_data = OPCODE;
            ADDR_PAGE: mem_data = PAGE;
            ADDR_LOW: mem_data = 8'h3C;
            default: mem_data = ~fetch_addr[7:0];
        endcase
    end
    // take the interrupt, then fetch entry, page and low byte
    always_ff @(posedge clk) begin
        ack <= go && st_r == 3'h0;
        done <= st_r == 3'h4;
        st_r <= (st_r == 3'h0 && !go) ? 3'h0 : st_r + 3'h1;
        case (st_r)
            3'h0: fetch_addr <= ADDR_ENTRY;
            3'h1: fetch_addr <= ADDR_PAGE;
            3'h2: begin
                fetch_addr <= ADDR_LOW;
                op_got <= fetch_data;
            end
            3'h3: page_got <= fetch_data;
            default: vec_got <= fetch_data;
        endcase
        if (st_r >= 3'h3) begin
            fetch_addr <= 16'hFFFF;
        end
        if (st_r == 3'h4 || rst) begin
            st_r <= 3'h0;
        end
    end
endmodule // fwia_core_model

// *** verification/fwia_autovector_tb_top.sv ***
// fwia_autovector_tb_top: bench for the fifo/waveform autovector block
`timescale 1ns/1ns
module fwia_autovector_tb_top;
    import fwia_pkg::*;
    localparam logic [7:0] PAGE = 8'h12;
    localparam logic [7:0] OP = 8'h02;
    // expected codes, lowest byte is priority one
    localparam logic [111:0] VEC_TAB = {8'hB4, 8'hB0, 8'hAC, 8'hA8,
        8'hA4, 8'hA0, 8'h9C, 8'h98, 8'h94, 8'h90, 8'h8C, 8'h88,
        8'h84, 8'h80};
    logic CORE_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [13:0] ev = '0;
    logic [13:0] clr_v = '0;
    logic en_wr = 1'b0;
    logic en_val = 1'b0;
    logic go = 1'b0;
    logic ack, done, irq, subst_en;
    logic [15:0] f_addr;
    logic [7:0] f_mem, f_data, code, page_got, vec_got, op_got;
    logic [13:0] pend;
    int n_mismatch = 0;
    int n_compared = 0;
    fwia_autovector #(.N(14)) dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
        .CLK_EN(1'b1), .LEVEL_FLAGS(ev[3:0]), .EMPTY_FLAGS(ev[7:4]),
        .FULL_FLAGS(ev[11:8]), .WAVE_DONE(ev[12]), .WAVE_EVENT(ev[13]),
        .SRC_CLEAR(clr_v), .SUBST_EN_WR(en_wr), .SUBST_EN_VAL(en_val),
        .IRQ_ACK(ack), .FETCH_ADDR(f_addr), .FETCH_MEM_DATA(f_mem),
        .FETCH_DATA(f_data), .FIFO_EVENT_IRQ_LINE(irq),
        .FIFO_EVENT_VECTOR_CODE(code), .PENDING(pend), .SUBST_EN(subst_en));
    fwia_core_model #(.PAGE(PAGE), .OPCODE(OP)) core (.clk(CORE_CLK),
        .rst(SYS_RST), .go(go), .fetch_data(f_data), .fetch_addr(f_addr),
        .mem_data(f_mem), .ack(ack), .done(done), .op_got(op_got),
        .page_got(page_got), .vec_got(vec_got));
    initial forever #4 CORE_CLK = ~CORE_CLK;
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask
    task automatic pulse(input logic [13:0] m, input logic is_clr);
        @(posedge CORE_CLK);
        if (is_clr) clr_v <= m;
        else ev <= m;
        @(posedge CORE_CLK);
        clr_v <= '0;
        ev <= '0;
        tick(3);
    endtask
    task automatic set_en(input logic v);
        @(posedge CORE_CLK);
        en_wr <= 1'b1;
        en_val <= v;
        @(posedge CORE_CLK);
        en_wr <= 1'b0;
        tick(2);
    endtask
    // core takes the interrupt and fetches the jump bytes
    task automatic fetch;
        int k;
        @(posedge CORE_CLK);
        go <= 1'b1;
        @(posedge CORE_CLK);
        go <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        chk(8'h01, {7'h00, done});
        chk(OP, op_got);
        chk(PAGE, page_got);
    endtask
    // all sources at once, retired one by one in priority order
    task automatic t_prio;
        set_en(1'b1);
        chk(8'h01, {7'h00, subst_en});
        pulse('1, 1'b0);
        chk(8'hFF, pend[7:0]);
        chk(8'h3F, {2'h0, pend[13:8]});
        for (int i = 0; i < 14; i++) begin
            chk(VEC_TAB[i*8 +: 8], code);
            chk(8'h01, {7'h00, irq});
            fetch();
            chk(VEC_TAB[i*8 +: 8], vec_got);
            pulse(14'(1 << i), 1'b1);
        end
        chk(8'h00, {7'h00, irq});
        $display("test prio done");
    endtask
    // substitution off: low byte comes from memory
    task automatic t_off;
        set_en(1'b0);
        chk(8'h00, {7'h00, subst_en});
        pulse(14'h2000, 1'b0);
        chk(VEC_WAVE_EVENT, code);
        fetch();
        chk(8'h3C, vec_got);
        pulse(14'h2000, 1'b1);
        $display("test off done");
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // events during reset must not survive it
    initial begin
        ev <= '1;
        repeat (8) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        ev <= '0;
        tick(2);
        chk(8'h00, pend[7:0]);
        chk(8'h00, {2'h0, pend[13:8]});
        chk(8'h00, {6'h00, irq, subst_en});
        $display("test reset done");
        t_prio();
        t_off();
        wrap_up();
    end
    initial begin
        #40000;
        n_mismatch++;
        wrap_up();
    end
endmodule // fwia_autovector_tb_top
